// ---- common/rsc_regs.svh ----
/*
  timing counts, field widths and format constants of the radar sample
  capture formatter; assumes inclusion by bare name from package or rtl.
*/
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ------------------------------------------------------------
// sample path
// ------------------------------------------------------------
`define RSC_NUM_CHAN        6
`define RSC_SAMPLE_BITS     8
`define RSC_BUF_BYTES       16384
`define RSC_BUF_AW          14
`define RSC_FIFO_DEPTH      4

// ------------------------------------------------------------
// rates
// ------------------------------------------------------------
`define RSC_CLK_MHZ         100
`define RSC_RATE_NARROW_MHZ 45
`define RSC_RATE_WIDE_MHZ   90
`define RSC_REC_MBPS        32
// phase accumulator modulus for fractional rate generation
`define RSC_PHASE_MOD       100
// output pacing: one byte each ceil(clk / recorder rate) cycles
`define RSC_OUT_GAP         ((`RSC_CLK_MHZ + `RSC_REC_MBPS - 1) / `RSC_REC_MBPS)

// ------------------------------------------------------------
// record format
// ------------------------------------------------------------
`define RSC_SYNC_BYTE       8'he5
`define RSC_TLM_BYTES       4

`endif

// ---- common/rsc_pkg.sv ----
/*
  types of the radar sample capture formatter; assumes rsc_regs.svh.
*/
`default_nettype none
`include "rsc_regs.svh"
package rsc_pkg;
  typedef enum logic [2:0] {
    RSC_IDLE  = 3'b000,
    RSC_CAPT  = 3'b001,
    RSC_SYNC  = 3'b010,
    RSC_TLM   = 3'b011,
    RSC_DATA  = 3'b100
  } rsc_state_e;
  typedef logic [`RSC_SAMPLE_BITS-1:0] rsc_byte_t;
endpackage
`default_nettype wire

// ---- rtl/rsc_fifo.sv ----
/*
  small synchronous fifo with valid/ready on both sides;
  assumes one clock and asynchronous active-high reset.
*/
`default_nettype none
module rsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rsc_formatter.sv ----
/*
  radar sample capture and range-line formatter: six channel capture
  buffers, record window gating, multiplexed readout with telemetry
  header, paced dual output through a small fifo.
  assumes converters deliver samples synchronous to clk, qualified by
  the common sample strobe this block produces.
*/
`default_nettype none
`include "rsc_regs.svh"
module rsc_formatter
  import rsc_pkg::*;
#(
  parameter int NCH     = `RSC_NUM_CHAN,
  parameter int DEPTH   = `RSC_BUF_BYTES,
  parameter int OUT_GAP = `RSC_OUT_GAP
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        wide_mode,
  input  wire logic                        record_window,
  input  wire logic [NCH*`RSC_SAMPLE_BITS-1:0] adc_data,
  input  wire logic [31:0]                 telemetry,
  output logic                             sample_strobe,
  output logic [7:0]                       tape_recorder_data,
  output logic                             tape_recorder_valid,
  output logic [7:0]                       correlator_data,
  output logic                             correlator_valid,
  output logic                             line_start,
  output logic                             busy
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(NCH);

  // ------------------------------------------------------------
  // capture buffers
  // ------------------------------------------------------------
  rsc_byte_t buf_mem [NCH][DEPTH];

  rsc_state_e      state_reg;
  logic [7:0]      phase_reg;
  logic            strobe_reg;
  logic [AW:0]     wr_cnt_reg;
  logic [AW:0]     rd_idx_reg;
  logic [CW-1:0]   ch_reg;
  logic [1:0]      tlm_idx_reg;
  logic [31:0]     tlm_latch_reg;
  logic [31:0]     tlm_live_reg;
  logic            win_d_reg;
  logic [7:0]      gap_reg;
  rsc_byte_t       fmt_byte;
  logic            fmt_valid;
  logic            fifo_in_ready;
  rsc_byte_t       fifo_out_data;
  logic            fifo_out_valid;
  logic            pace_ok;

  function automatic rsc_byte_t lane(input logic [NCH*`RSC_SAMPLE_BITS-1:0] d, input int unsigned i);
    lane = d[i*`RSC_SAMPLE_BITS +: `RSC_SAMPLE_BITS];
  endfunction

  // ------------------------------------------------------------
  // common sample strobe
  // ------------------------------------------------------------
  // fractional accumulator: average rate exact, edge jitter one clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg  <= '0;
      strobe_reg <= 1'b0;
    end else begin
      logic [8:0] acc;
      acc = {1'b0, phase_reg} + (wide_mode ? 9'(`RSC_RATE_WIDE_MHZ) : 9'(`RSC_RATE_NARROW_MHZ));
      if (acc >= 9'(`RSC_PHASE_MOD)) begin
        phase_reg  <= 8'(acc - 9'(`RSC_PHASE_MOD));
        strobe_reg <= 1'b1;
      end else begin
        phase_reg  <= acc[7:0];
        strobe_reg <= 1'b0;
      end
    end
  end
  assign sample_strobe = strobe_reg;

  // ------------------------------------------------------------
  // telemetry, sampled every cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tlm_live_reg <= '0;
    end else begin
      tlm_live_reg <= telemetry;
    end
  end

  // ------------------------------------------------------------
  // capture write
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state_reg == RSC_CAPT && record_window && strobe_reg && wr_cnt_reg < (AW+1)'(DEPTH)) begin
      for (int i = 0; i < NCH; i++) begin
        buf_mem[i][AW'(wr_cnt_reg)] <= lane(adc_data, i);
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // a line begins on the rising edge of the window; samples in other
  // states are dropped, so a window during readout is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= RSC_IDLE;
      wr_cnt_reg    <= '0;
      rd_idx_reg    <= '0;
      ch_reg        <= '0;
      tlm_idx_reg   <= '0;
      tlm_latch_reg <= '0;
      win_d_reg     <= 1'b0;
    end else begin
      win_d_reg <= record_window;
      case (state_reg)
        RSC_IDLE: begin
          if (record_window && !win_d_reg) begin
            state_reg  <= RSC_CAPT;
            wr_cnt_reg <= '0;
          end
        end
        RSC_CAPT: begin
          if (record_window && strobe_reg && wr_cnt_reg < (AW+1)'(DEPTH)) begin
            wr_cnt_reg <= wr_cnt_reg + 1'b1;
          end
          if (!record_window) begin
            state_reg     <= RSC_SYNC;
            tlm_latch_reg <= tlm_live_reg;
            tlm_idx_reg   <= '0;
            rd_idx_reg    <= '0;
            ch_reg        <= '0;
          end
        end
        RSC_SYNC: begin
          if (fifo_in_ready) begin
            state_reg <= RSC_TLM;
          end
        end
        RSC_TLM: begin
          if (fifo_in_ready) begin
            tlm_idx_reg <= tlm_idx_reg + 1'b1;
            if (tlm_idx_reg == 2'(`RSC_TLM_BYTES-1)) begin
              state_reg <= (wr_cnt_reg == '0) ? RSC_IDLE : RSC_DATA;
            end
          end
        end
        RSC_DATA: begin
          if (fifo_in_ready) begin
            if (ch_reg == CW'(NCH-1)) begin
              ch_reg     <= '0;
              rd_idx_reg <= rd_idx_reg + 1'b1;
              if (rd_idx_reg + 1'b1 == wr_cnt_reg) begin
                state_reg <= RSC_IDLE;
              end
            end else begin
              ch_reg <= ch_reg + 1'b1;
            end
          end
        end
        default: state_reg <= RSC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // record byte mux
  // ------------------------------------------------------------
  always_comb begin
    fmt_byte  = '0;
    fmt_valid = 1'b0;
    case (state_reg)
      RSC_SYNC: begin
        fmt_byte  = `RSC_SYNC_BYTE;
        fmt_valid = 1'b1;
      end
      RSC_TLM: begin
        fmt_byte  = tlm_latch_reg[8*(3-tlm_idx_reg) +: 8];
        fmt_valid = 1'b1;
      end
      RSC_DATA: begin
        fmt_byte  = buf_mem[ch_reg][AW'(rd_idx_reg)];
        fmt_valid = 1'b1;
      end
      default: begin
        fmt_byte  = '0;
        fmt_valid = 1'b0;
      end
    endcase
  end

  rsc_fifo #(
    .WIDTH (`RSC_SAMPLE_BITS),
    .DEPTH (`RSC_FIFO_DEPTH)
  ) i_rsc_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (fmt_byte),
    .in_valid  (fmt_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (pace_ok)
  );

  // ------------------------------------------------------------
  // paced dual output
  // ------------------------------------------------------------
  // pacing backs up into the fifo, which stalls the sequencer
  assign pace_ok = (gap_reg == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg             <= '0;
      tape_recorder_data  <= '0;
      tape_recorder_valid <= 1'b0;
      correlator_data     <= '0;
      correlator_valid    <= 1'b0;
      line_start          <= 1'b0;
      busy                <= 1'b0;
    end else begin
      busy <= (state_reg != RSC_IDLE);
      if (fifo_out_valid && pace_ok) begin
        gap_reg             <= 8'(OUT_GAP - 1);
        tape_recorder_data  <= fifo_out_data;
        correlator_data     <= fifo_out_data;
        tape_recorder_valid <= 1'b1;
        correlator_valid    <= 1'b1;
      end else begin
        if (gap_reg != '0) begin
          gap_reg <= gap_reg - 1'b1;
        end
        tape_recorder_valid <= 1'b0;
        correlator_valid    <= 1'b0;
      end
      line_start <= (state_reg == RSC_SYNC) && fifo_in_ready;
    end
  end
endmodule
`default_nettype wire

// ---- verification/rsc_formatter_monitor.sv ----
/*
  port checker of the range-line formatter;
  assumes a bind from the bench top and one clock domain.
*/
`default_nettype none
module rsc_formatter_monitor #(
  parameter int NCH     = 6,
  parameter int DEPTH   = 16,
  parameter int OUT_GAP = 4
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             wide_mode,
  input wire logic             record_window,
  input wire logic [NCH*8-1:0] adc_data,
  input wire logic [31:0]      telemetry,
  input wire logic             sample_strobe,
  input wire logic [7:0]       tape_recorder_data,
  input wire logic             tape_recorder_valid,
  input wire logic [7:0]       correlator_data,
  input wire logic             correlator_valid,
  input wire logic             line_start,
  input wire logic             busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_dual_valid: assert property (tape_recorder_valid == correlator_valid)
    else $error("outputs disagree on valid");
  a_dual_data: assert property (tape_recorder_valid |-> tape_recorder_data == correlator_data)
    else $error("outputs disagree on data");
  a_byte_gap: assert property (tape_recorder_valid |=> !tape_recorder_valid [*3])
    else $error("bytes closer than four cycles");
  // mode held three cycles so the accumulator has settled
  a_narrow_strobe: assert property (!wide_mode [*3] ##0 sample_strobe |=> !sample_strobe)
    else $error("narrow strobe twice in a row");
  a_wide_strobe: assert property (wide_mode [*3] ##0 !sample_strobe |=> sample_strobe)
    else $error("wide strobe missed twice");
  a_sync_first: assert property (line_start |=> tape_recorder_valid && tape_recorder_data == 8'he5)
    else $error("record does not open with sync");
  a_start_close: assert property (line_start |-> busy && !$past(record_window))
    else $error("record start without window close");
  a_window_start: assert property ($rose(record_window) && !busy |-> ##[1:3] busy)
    else $error("window did not start a line");
endmodule
`default_nettype wire

// ---- verification/rsc_recorder_model.sv ----
/*
  recorder and correlator sink: stores record bytes, counts faults;
  assumes outputs change on the rising clock edge.
*/
`default_nettype none
module rsc_recorder_model (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] rec_data,
  input wire logic       rec_valid,
  input wire logic [7:0] cor_data,
  input wire logic       cor_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bytes[$];
  int         gap = 100;
  int         faults = 0;
  always @(posedge clk) begin
    gap++;
    if (rec_valid !== cor_valid || (rec_valid && rec_data !== cor_data)) faults++;
    if (rec_valid === 1'b1 && !rst) begin
      if (gap < 4) faults++;
      bytes.push_back(rec_data);
      gap = 0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/rsc_formatter_tb.sv ----
/*
  self-checking bench of the formatter;
  assumes a 100 MHz clock and a shortened buffer depth.
*/
`default_nettype none
module rsc_formatter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 16;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wide_mode = 1'b0;
  logic        record_window = 1'b0;
  logic [47:0] adc_data = '0;
  logic [31:0] telemetry = '0;
  logic [4:0]  g = '0;
  wire logic [7:0] rec_data, cor_data;
  wire logic   rec_valid, cor_valid, sample_strobe, line_start, busy;
  int          n_errors = 0;
  int          comparisons = 0;
  int          lines = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (line_start === 1'b1) lines++;
  rsc_formatter #(.DEPTH(DEPTH)) i_rsc_formatter (.clk(clk), .rst(rst), .wide_mode(wide_mode),
    .record_window(record_window), .adc_data(adc_data), .telemetry(telemetry), .sample_strobe(sample_strobe),
    .tape_recorder_data(rec_data), .tape_recorder_valid(rec_valid), .correlator_data(cor_data),
    .correlator_valid(cor_valid), .line_start(line_start), .busy(busy));
  rsc_recorder_model i_rsc_recorder_model (.clk(clk), .rst(rst), .rec_data(rec_data), .rec_valid(rec_valid),
    .cor_data(cor_data), .cor_valid(cor_valid));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [47:0] pat(input logic [4:0] v);
    for (int i = 0; i < 6; i++) pat[8*i +: 8] = {v, 3'(i)};
  endfunction
  function automatic logic [7:0] rb(input int i);
    return i_rsc_recorder_model.bytes[i];
  endfunction
  task automatic give_verdict();
    $display("counts: %0d errors, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    cyc(16);
    check({rec_valid, cor_valid, sample_strobe, line_start, busy}, 0);
    rst = 1'b0;
    $display("reset test done");
  endtask
  task automatic t_rate(input logic wide, input int exp);
    int c;
    wide_mode = wide;
    cyc(4);
    c = 0;
    repeat (200) begin
      cyc(1);
      if (sample_strobe === 1'b1) c++;
    end
    check(c >= exp - 1 && c <= exp + 1, 1);
    $display("rate test done: %0d strobes", c);
  endtask
  // a late window pulse during readout must be ignored
  task automatic run_line(input logic wide, input int nstb, input logic [31:0] tlm);
    int k, n, lo, hi, t, l0;
    logic prev;
    logic [4:0] g0;
    wide_mode = wide;
    cyc(4);
    i_rsc_recorder_model.bytes.delete();
    l0 = lines;
    telemetry = tlm;
    g0 = g;
    record_window = 1'b1;
    k = 0;
    prev = 1'b0;
    while (k < nstb) begin
      cyc(1);
      if (prev) begin
        g++;
        adc_data = pat(g);
        k++;
      end
      prev = sample_strobe;
    end
    record_window = 1'b0;
    cyc(6);
    telemetry = ~tlm;
    record_window = 1'b1;
    cyc(5);
    record_window = 1'b0;
    t = 0;
    while (busy === 1'b1 && t < 3000) begin
      cyc(1);
      t++;
    end
    check(t < 3000, 1);
    // fifo may still hold four bytes at four cycles each
    cyc(40);
    n = (i_rsc_recorder_model.bytes.size() - 5) / 6;
    hi = (nstb < DEPTH) ? nstb : DEPTH;
    lo = (nstb - 1 < DEPTH) ? nstb - 1 : DEPTH;
    check(lines - l0, 1);
    check(n >= lo && n <= hi, 1);
    check((i_rsc_recorder_model.bytes.size() - 5) % 6, 0);
    check(rb(0), 8'he5);
    check({rb(1), rb(2), rb(3), rb(4)}, tlm);
    check(5'(rb(5) >> 3) - g0 <= 5'd1, 1);
    for (int j = 0; j < n; j++)
      for (int i = 0; i < 6; i++)
        check(rb(5 + 6 * j + i), {5'((rb(5) >> 3) + j), 3'(i)});
    check(i_rsc_recorder_model.faults, 0);
    $display("line test done: %0d groups", n);
  endtask
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    adc_data = pat(g);
    t_reset();
    t_rate(1'b0, 90);
    t_rate(1'b1, 180);
    run_line(1'b0, 10, 32'h1234abcd);
    run_line(1'b1, 40, 32'hc0de5a17);
    give_verdict();
  end
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end
endmodule
bind rsc_formatter rsc_formatter_monitor #(.NCH(NCH), .DEPTH(DEPTH), .OUT_GAP(OUT_GAP)) i_rsc_formatter_monitor (
  .clk(clk), .rst(rst), .wide_mode(wide_mode), .record_window(record_window), .adc_data(adc_data),
  .telemetry(telemetry), .sample_strobe(sample_strobe), .tape_recorder_data(tape_recorder_data),
  .tape_recorder_valid(tape_recorder_valid), .correlator_data(correlator_data),
  .correlator_valid(correlator_valid), .line_start(line_start), .busy(busy));
`default_nettype wire
